// >>> core/fsf_pkg.sv
// Shared constants and types for the serial frame follower
package fsf_pkg;

  // Character and clock figures
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned BAUD_MIN   = 2400;
  localparam int unsigned BAUD_MAX   = 115200;
  localparam logic [15:0] DIV_MIN    = 16'(CLK_HZ / BAUD_MAX);
  localparam logic [15:0] DIV_MAX    = 16'(CLK_HZ / BAUD_MIN);
  localparam logic [3:0]  CHAR_BITS  = 4'hb;
  localparam int unsigned FIFO_DEPTH = 32;

  // Frame layout
  localparam logic [7:0] START_BYTE  = 8'h02;
  localparam logic [7:0] LEN_OVERHD  = 8'h02;
  localparam logic [7:0] LEN_PROC    = 8'h06;
  localparam logic [7:0] LEN_PARAM   = 8'h0e;
  localparam logic [7:0] TEXT_FIXED  = 8'h0a;
  localparam logic [7:0] PARAM_BYTES = 8'h0c;
  localparam int unsigned CODE_LSB   = 12;

  // Address byte fields
  localparam int unsigned ADR_LONG  = 7;
  localparam int unsigned ADR_BCAST = 5;

  // Parameter commands, master to follower
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_READ = 4'h1, CMD_WR_W = 4'h2, CMD_WR_DW = 4'h3,
    CMD_NV_DW = 4'hd, CMD_NV_W = 4'he, CMD_TEXT = 4'hf
  } fsf_cmd_t;

  // Response codes, follower to master
  typedef enum logic [3:0] {
    RES_NONE = 4'h0, RES_WORD = 4'h1, RES_DWORD = 4'h2, RES_FAIL = 4'h7, RES_TEXT = 4'hf
  } fsf_res_t;

  // Fault reports placed in the low value word
  localparam logic [7:0] FLT_NO_PARAM = 8'h00;
  localparam logic [7:0] FLT_NO_WRITE = 8'h01;
  localparam logic [7:0] FLT_RANGE    = 8'h02;
  localparam logic [7:0] FLT_NO_SUB   = 8'h03;
  localparam logic [7:0] FLT_NO_ARRAY = 8'h04;
  localparam logic [7:0] FLT_TYPE     = 8'h05;
  localparam logic [7:0] FLT_MODE     = 8'h11;
  localparam logic [7:0] FLT_NO_BUS   = 8'h82;
  localparam logic [7:0] FLT_FACTORY  = 8'h83;

  // Decoded command flags
  typedef struct packed {
    logic rd;
    logic wr;
    logic dword;
    logic nonvol;
    logic text;
    logic bad;
  } fsf_dec_t;

  // Request handed to the drive logic
  typedef struct packed {
    logic        bcast;
    logic        has_param;
    fsf_cmd_t    cmd;
    fsf_dec_t    dec;
    logic [11:0] param_number;
    logic [15:0] index;
    logic [31:0] value;
    logic [15:0] ctrl_word;
    logic [15:0] reference;
  } fsf_req_t;

  // Answer from the drive logic
  typedef struct packed {
    fsf_res_t    code;
    logic [7:0]  fault;
    logic [31:0] value;
    logic [15:0] status_word;
    logic [15:0] out_freq;
  } fsf_rsp_t;

endpackage

// >>> core/fsf_follower.sv
// Serial frame follower: character engine, frame parser, reply builder, byte FIFO
// Operation
// RULE1: start, eight data, parity, stop bits
// RULE2: parity makes ones count even
// RULE3: bit rate settable, even parity default
// RULE4: start 0x02, length, address, data, checksum
// RULE5: length equals data bytes plus two
// RULE6: text length is ten plus text
// RULE7: short address, bit5 broadcast, bits0-4 node
// RULE8: long address, bits0-6 node, zero broadcast
// RULE9: reply echoes received address byte unchanged
// RULE10: checksum is XOR from zero
// RULE11: process block four bytes, two words
// RULE12: parameter block twelve bytes, both directions
// RULE13: key bits 12-15 carry command/response
// RULE14: decode the seven command codes
// RULE15: encode the five response codes
// RULE16: failure gives 0111 and fault code
// RULE17: fault codes 11, 82, 83 too
// RULE18: control word passed to drive logic
// RULE19: reply only when addressed, half duplex
// RULE20: control/status word first, then reference
// RULE21: drop bad parity, checksum, address frames
// RULE22: never reply to broadcast frames
`timescale 1ns/1ps
`default_nettype none

module fsf_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned D = 32
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(D);

  // Pointers carry one extra bit so full and empty differ
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fsf_fifo_st_t;

  fsf_fifo_st_t         q, d;
  logic [W-1:0]         mem [D];    // Storage words
  logic                 push, pop;  // Accepted transfers

  assign in_ready_o  = (q.wp[AW-1:0] != q.rp[AW-1:0]) || (q.wp[AW] == q.rp[AW]);
  assign out_valid_o = q.wp != q.rp;
  assign out_data_o  = mem[q.rp[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer advance
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.wp = q.wp + 1'b1;
    end
    if (pop)
    begin
      d.rp = q.rp + 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[q.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

module fsf_follower
  import fsf_pkg::*;
(
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           reset_i,
  // Serial line
  input  wire logic           rxd_i,
  output logic                txd_o,
  output logic                tx_en_o,
  // Configuration
  input  wire logic [6:0]     node_addr_i,
  input  wire logic [15:0]    baud_div_i,
  // Request to drive logic
  output logic                req_valid_o,
  output fsf_pkg::fsf_req_t   req_o,
  // Answer from drive logic
  input  wire logic           rsp_valid_i,
  output logic                rsp_ready_o,
  input  wire fsf_pkg::fsf_rsp_t rsp_i,
  // Status pulses
  output logic                frame_drop_o,
  output logic                overrun_o
);
  import fsf_pkg::*;

  typedef enum logic [2:0] {P_IDLE, P_LEN, P_ADDR, P_DATA, P_CHK, P_WAIT, P_SEND} fsf_pst_t;

  // Whole module state
  typedef struct packed {
    logic        sync1;      // Line synchroniser, first stage
    logic        sync2;      // Line synchroniser, second stage
    logic        rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [9:0]  rx_sh;
    logic        rx_stb;     // One byte landed
    logic [8:0]  rx_word;    // Error flag and byte
    fsf_pst_t    st;
    logic [7:0]  len;
    logic [7:0]  cnt;
    logic [7:0]  xr;
    logic [7:0]  addr;
    logic        bad;
    logic        bcast;
    logic [95:0] buf_q;      // First twelve data bytes
    fsf_rsp_t    rsp;
    logic [7:0]  tx_idx;
    logic [7:0]  tx_xr;
    logic        tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [10:0] tx_sh;
    logic        req_valid;
    fsf_req_t    req;
    logic        drop;
    logic        ovr;
  } fsf_st_t;

  fsf_st_t    q, d;
  logic       f_valid, f_ready;  // FIFO drain handshake
  logic [8:0] f_word;            // Error flag and byte
  logic       f_in_ready;        // FIFO room

  // Even parity bit over a byte
  function automatic logic par_even(input logic [7:0] b);
    return ^b;  // [RULE2]
  endfunction

  // Command field decode
  function automatic fsf_dec_t cmd_decode(input logic [3:0] c);
    fsf_dec_t r;
    r = '0;
    unique case (c)  // [RULE14]
      CMD_NONE:  r = '0;
      CMD_READ:  r.rd = 1'b1;
      CMD_WR_W:  r.wr = 1'b1;
      CMD_WR_DW: begin r.wr = 1'b1; r.dword = 1'b1; end
      CMD_NV_DW: begin r.wr = 1'b1; r.dword = 1'b1; r.nonvol = 1'b1; end
      CMD_NV_W:  begin r.wr = 1'b1; r.nonvol = 1'b1; end
      CMD_TEXT:  r.text = 1'b1;
      default:   r.bad = 1'b1;
    endcase
    return r;
  endfunction

  // Address match and broadcast test; returns {accept, broadcast}
  function automatic logic [1:0] addr_check(input logic [7:0] a, input logic [6:0] me);
    logic [1:0] r;
    r = 2'b00;
    if (a[ADR_LONG])
    begin
      if (a[6:0] == 7'h00)  // [RULE8]
      begin
        r = 2'b11;
      end
      else
      begin
        r = {a[6:0] == me, 1'b0};
      end
    end
    else if (a[ADR_BCAST])  // [RULE7]
    begin
      r = 2'b11;
    end
    else
    begin
      r = {(a[4:0] == me[4:0]) && (me[6:5] == 2'b00), 1'b0};
    end
    return r;
  endfunction

  // Byte k of the reply data field
  function automatic logic [7:0] reply_byte(input fsf_st_t s, input logic [7:0] k);
    logic [95:0] v;
    logic [3:0]  code;
    logic [31:0] val;
    code = s.rsp.code;
    val  = s.rsp.value;
    if (s.rsp.code == RES_FAIL)
    begin
      val = {24'h0, s.rsp.fault};  // [RULE16] [RULE17]
    end
    if (s.len < LEN_PARAM)
    begin
      v = {s.rsp.status_word, s.rsp.out_freq, 64'h0};  // [RULE11] [RULE20]
    end
    else
    begin
      v = {code, s.req.param_number, s.req.index, val,  // [RULE12] [RULE13] [RULE15]
           s.rsp.status_word, s.rsp.out_freq};
    end
    if (k >= PARAM_BYTES)
    begin
      return 8'h00;
    end
    return v[95 - 8 * k[3:0] -: 8];
  endfunction

  // Received bytes queue here while the parser waits for the answer; the receiver detects no new start bit while a reply character is sent
  fsf_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (q.rx_stb),
    .in_ready_o  (f_in_ready),
    .in_data_i   (q.rx_word),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_word)
  );

  // Parser stalls while waiting for or sending a reply
  assign f_ready     = (q.st != P_WAIT) && (q.st != P_SEND);
  assign rsp_ready_o = q.st == P_WAIT;
  assign txd_o        = q.tx_busy ? q.tx_sh[0] : 1'b1;
  assign tx_en_o      = q.st == P_SEND;  // [RULE19]
  assign req_valid_o  = q.req_valid;
  assign req_o        = q.req;
  assign frame_drop_o = q.drop;
  assign overrun_o    = q.ovr;

  // Next state
  always_comb
  begin
    logic [7:0] b;
    logic [1:0] ac;
    logic [7:0] nb;
    b  = f_word[7:0];
    ac = 2'b00;
    nb = 8'h00;
    d  = q;
    d.rx_stb    = 1'b0;
    d.req_valid = 1'b0;
    d.drop      = 1'b0;
    d.ovr       = q.rx_stb && !f_in_ready;

    // Line synchroniser
    d.sync1 = rxd_i;
    d.sync2 = q.sync1;

    // Receiver: half a bit to the start centre, then ten full bits
    if (!q.rx_busy)
    begin
      if (!q.sync2 && !q.tx_busy)
      begin
        d.rx_busy = 1'b1;
        d.rx_cnt  = baud_div_i >> 1;  // [RULE3]
        d.rx_bit  = 4'h0;
      end
    end
    else if (q.rx_cnt != 16'h0)
    begin
      d.rx_cnt = q.rx_cnt - 16'h1;
    end
    else
    begin
      d.rx_cnt = baud_div_i - 16'h1;
      d.rx_bit = q.rx_bit + 4'h1;
      if (q.rx_bit == 4'h0)
      begin
        d.rx_busy = !q.sync2;  // Glitch, not a start bit
      end
      else
      begin
        d.rx_sh = {q.sync2, q.rx_sh[9:1]};
      end
      if (q.rx_bit == CHAR_BITS - 4'h1)  // [RULE1]
      begin
        d.rx_busy = 1'b0;
        d.rx_stb  = 1'b1;
        d.rx_word = {(^q.rx_sh[9:1]) || !q.sync2, q.rx_sh[8:1]};  // [RULE2]
      end
    end

    // Frame parser
    if (f_valid && f_ready)
    begin
      d.xr = q.xr ^ b;  // [RULE10]
      d.bad = q.bad | f_word[8];
      unique case (q.st)
        P_IDLE:
        begin
          d.xr  = b;
          d.bad = 1'b0;
          if (b != START_BYTE || f_word[8])  // [RULE4]
          begin
            d.st = P_IDLE;
          end
          else
          begin
            d.st = P_LEN;
          end
        end
        P_LEN:
        begin
          d.len = b;
          d.st  = (b < LEN_OVERHD) ? P_IDLE : P_ADDR;
        end
        P_ADDR:
        begin
          d.addr = b;
          d.cnt  = 8'h00;
          d.st   = (q.len == LEN_OVERHD) ? P_CHK : P_DATA;  // [RULE5] [RULE6]
        end
        P_DATA:
        begin
          if (q.cnt < PARAM_BYTES)
          begin
            d.buf_q[95 - 8 * q.cnt[3:0] -: 8] = b;
          end
          d.cnt = q.cnt + 8'h1;
          if (q.cnt + 8'h1 == q.len - LEN_OVERHD)
          begin
            d.st = P_CHK;
          end
        end
        P_CHK:
        begin
          ac = addr_check(q.addr, node_addr_i);
          d.st = P_IDLE;
          if (q.xr != b || q.bad || f_word[8] || !ac[1])  // [RULE21]
          begin
            d.drop = 1'b1;
          end
          else
          begin
            d.req_valid     = 1'b1;
            d.req.bcast     = ac[0];
            d.req.has_param = q.len >= LEN_PARAM;
            if (q.len >= LEN_PARAM)
            begin
              d.req.cmd          = fsf_cmd_t'(q.buf_q[95:92]);  // [RULE13]
              d.req.dec          = cmd_decode(q.buf_q[95:92]);
              d.req.param_number = q.buf_q[91:80];
              d.req.index        = q.buf_q[79:64];
              d.req.value        = q.buf_q[63:32];
              d.req.ctrl_word    = q.buf_q[31:16];  // [RULE18] [RULE20]
              d.req.reference    = q.buf_q[15:0];
            end
            else
            begin
              d.req.cmd       = CMD_NONE;
              d.req.dec       = '0;
              d.req.ctrl_word = q.buf_q[95:80];  // [RULE11] [RULE18]
              d.req.reference = q.buf_q[79:64];
            end
            d.st = ac[0] ? P_IDLE : P_WAIT;  // [RULE22]
          end
        end
        default:
        begin
          d.st = q.st;
        end
      endcase
    end

    // Capture the answer, then send the reply byte by byte
    if (q.st == P_WAIT && rsp_valid_i)
    begin
      d.rsp    = rsp_i;
      d.tx_idx = 8'h00;
      d.tx_xr  = 8'h00;
      d.st     = P_SEND;
    end

    // Transmitter shifts least significant bit first
    if (q.tx_busy)
    begin
      if (q.tx_cnt != 16'h0)
      begin
        d.tx_cnt = q.tx_cnt - 16'h1;
      end
      else
      begin
        d.tx_cnt = baud_div_i - 16'h1;
        d.tx_sh  = {1'b1, q.tx_sh[10:1]};
        d.tx_bit = q.tx_bit + 4'h1;
        d.tx_busy = q.tx_bit != CHAR_BITS - 4'h1;
      end
    end
    else if (q.st == P_SEND)
    begin
      if (q.tx_idx == q.len + LEN_OVERHD)
      begin
        d.st = P_IDLE;
      end
      else
      begin
        if (q.tx_idx == 8'h00)
        begin
          nb = START_BYTE;  // [RULE4]
        end
        else if (q.tx_idx == 8'h01)
        begin
          nb = q.len;  // [RULE5]
        end
        else if (q.tx_idx == 8'h02)
        begin
          nb = q.addr;  // [RULE9]
        end
        else if (q.tx_idx == q.len + 8'h01)
        begin
          nb = q.tx_xr;  // [RULE10]
        end
        else
        begin
          nb = reply_byte(q, q.tx_idx - 8'h03);
        end
        d.tx_xr   = q.tx_xr ^ nb;
        d.tx_idx  = q.tx_idx + 8'h1;
        d.tx_busy = 1'b1;
        d.tx_bit  = 4'h0;
        d.tx_cnt  = baud_div_i - 16'h1;
        d.tx_sh   = {1'b1, par_even(nb), nb, 1'b0};  // [RULE1] [RULE2]
      end
    end
  end

  // State register; line idles high
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      q       <= '0;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.st    <= P_IDLE;
    end
    else
    begin
      q <= d;
    end
  end
endmodule

`default_nettype wire

// >>> dv/fsf_follower_props.sv
// Port-level checks on the serial frame follower
`timescale 1ns/1ps
`default_nettype none
module fsf_follower_props
  import fsf_pkg::*;
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              reset_i,
  // Serial line
  input wire logic              rxd_i,
  input wire logic              txd_o,
  input wire logic              tx_en_o,
  // Configuration
  input wire logic [6:0]        node_addr_i,
  input wire logic [15:0]       baud_div_i,
  // Request and answer
  input wire logic              req_valid_o,
  input wire fsf_pkg::fsf_req_t req_o,
  input wire logic              rsp_valid_i,
  input wire logic              rsp_ready_o,
  input wire fsf_pkg::fsf_rsp_t rsp_i,
  // Status pulses
  input wire logic              frame_drop_o,
  input wire logic              overrun_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Line rests high whenever the driver is off
  idle_line_high_a: assert property (!tx_en_o |-> txd_o) else $error("line low with driver off");
  // First edge after reset finds everything quiet
  reset_quiet_a: assert property ($fell(reset_i) |-> txd_o && !tx_en_o && !rsp_ready_o && !req_valid_o)
    else $error("outputs busy after reset");
  // A request is a single-cycle pulse
  req_pulse_a: assert property (req_valid_o |=> !req_valid_o) else $error("request pulse too long");
  // Broadcast requests ask for no answer in the next eight cycles
  bcast_silent_a: assert property (req_valid_o && req_o.bcast |=> !rsp_ready_o [*8])
    else $error("answer asked for broadcast");
  // Addressed requests wait for the answer next cycle
  own_wait_a: assert property (req_valid_o && !req_o.bcast |=> rsp_ready_o) else $error("no wait for answer");
  // Taking the answer starts the reply
  take_send_a: assert property (rsp_valid_i && rsp_ready_o |=> tx_en_o && !rsp_ready_o)
    else $error("answer taken without reply");
  // The driver only turns on after an answer
  send_cause_a: assert property ($rose(tx_en_o) |-> $past(rsp_valid_i && rsp_ready_o))
    else $error("unprompted transmit");
  // Reply opens with a start bit soon after the driver turns on
  start_soon_a: assert property ($rose(tx_en_o) |-> ##[0:4] !txd_o) else $error("reply start late");
  // No answer is asked for while talking
  half_duplex_a: assert property (tx_en_o |-> !rsp_ready_o && !req_valid_o && !frame_drop_o)
    else $error("parser active while sending");
  // A dropped frame never yields a request
  drop_not_req_a: assert property (!(frame_drop_o && req_valid_o)) else $error("dropped frame requested");
  // Read command decoding
  dec_read_a: assert property (req_valid_o && req_o.cmd == CMD_READ |-> req_o.dec.rd && !req_o.dec.wr &&
    !req_o.dec.bad) else $error("read decoded wrongly");
  // Nonvolatile word write decoding
  dec_nvw_a: assert property (req_valid_o && req_o.cmd == CMD_NV_W |-> req_o.dec.wr && req_o.dec.nonvol &&
    !req_o.dec.dword) else $error("nonvolatile write decoded wrongly");
endmodule

bind fsf_follower fsf_follower_props u_props (
  .clk_i(clk_i), .reset_i(reset_i), .rxd_i(rxd_i), .txd_o(txd_o), .tx_en_o(tx_en_o),
  .node_addr_i(node_addr_i), .baud_div_i(baud_div_i), .req_valid_o(req_valid_o), .req_o(req_o),
  .rsp_valid_i(rsp_valid_i), .rsp_ready_o(rsp_ready_o), .rsp_i(rsp_i),
  .frame_drop_o(frame_drop_o), .overrun_o(overrun_o)
);
`default_nettype wire

// >>> dv/fsf_master.sv
// Behavioural bus master: sends frames, collects reply characters
`timescale 1ns/1ps
`default_nettype none
module fsf_master (
  // Clock and bit timing
  input  wire logic        clk_i,
  input  wire logic [15:0] baud_div_i,
  // Towards the follower
  output logic             line_o,
  // From the follower
  input  wire logic        txd_i,
  input  wire logic        tx_en_i
);
  logic [7:0]  rx_q[$];    // Reply characters in arrival order
  int          rx_bad = 0; // Reply characters with bad parity or stop bit
  logic [10:0] ch;         // Character being sampled

  initial line_o = 1'b1;

  // One character LSB first; flip breaks the parity on purpose
  task automatic send_byte(input logic [7:0] b, input bit flip);
    logic [10:0] c;
    c = {1'b1, ^b ^ flip, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line_o = c[i];
      repeat (baud_div_i) @(negedge clk_i);
    end
  endtask

  // Frame bytes then running XOR from zero, optionally corrupted
  task automatic send_frame(input logic [7:0] q[$], input logic [7:0] xf, input int bad);
    logic [7:0] x;
    x = 8'h00;
    foreach (q[i])
    begin
      send_byte(q[i], i == bad);
      x ^= q[i];
    end
    send_byte(x ^ xf, 1'b0);
  endtask

  // Mid-bit sampling only while the follower drives the line
  initial
  begin
    forever
    begin
      @(posedge clk_i);
      if (tx_en_i === 1'b1 && txd_i === 1'b0)
      begin
        repeat (baud_div_i / 2) @(posedge clk_i);
        for (int i = 1; i < 11; i++)
        begin
          repeat (baud_div_i) @(posedge clk_i);
          ch[i] = txd_i;
        end
        if (ch[10] !== 1'b1 || (^ch[9:1]) !== 1'b0)
          rx_bad++;
        rx_q.push_back(ch[8:1]);
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/fsf_follower_tb.sv
// Self-checking bench for the serial frame follower
`timescale 1ns/1ps
`default_nettype none
module fsf_follower_tb;
  import fsf_pkg::*;
  typedef logic [7:0] fsf_bq_t[$];

  logic        clk_i, reset_i, rxd, txd, tx_en, req_valid, rsp_valid, rsp_ready, frame_drop, overrun;
  logic [6:0]  node_addr;
  logic [15:0] baud_div;
  fsf_req_t    req, last_req;
  fsf_rsp_t    rsp;
  int          failures = 0, n_tests = 0, n_req = 0, n_drop = 0, n_ovr = 0, cycles = 0;

  fsf_follower dut (.clk_i(clk_i), .reset_i(reset_i), .rxd_i(rxd), .txd_o(txd), .tx_en_o(tx_en),
    .node_addr_i(node_addr), .baud_div_i(baud_div), .req_valid_o(req_valid), .req_o(req),
    .rsp_valid_i(rsp_valid), .rsp_ready_o(rsp_ready), .rsp_i(rsp), .frame_drop_o(frame_drop), .overrun_o(overrun));
  fsf_master m (.clk_i(clk_i), .baud_div_i(baud_div), .line_o(rxd), .txd_i(txd), .tx_en_i(tx_en));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Event counters and the hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (req_valid === 1'b1)
    begin
      n_req++;
      last_req = req;
    end
    if (frame_drop === 1'b1) n_drop++;
    if (overrun === 1'b1) n_ovr++;
    if (cycles == 60000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] xsum(input fsf_bq_t q);
    logic [7:0] x;
    x = 8'h00;
    foreach (q[i]) x ^= q[i];
    return x;
  endfunction

  // Expected flags; unknown codes are flagged, not refused
  function automatic fsf_dec_t xdec(input logic [3:0] c);
    fsf_dec_t d;
    d.rd = (c == 4'h1);
    d.wr = c inside {4'h2, 4'h3, 4'hd, 4'he};
    d.dword = c inside {4'h3, 4'hd};
    d.nonvol = c inside {4'hd, 4'he};
    d.text = (c == 4'hf);
    d.bad = !(c inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf});
    return d;
  endfunction

  // Send a frame and wait briefly for accept or drop
  task automatic exchange(input fsf_bq_t q, input logic [7:0] xf, input int bi, output bit got);
    int r0, d0;
    r0 = n_req;
    d0 = n_drop;
    m.rx_q.delete();
    m.send_frame(q, xf, bi);
    repeat (100) if (n_req == r0 && n_drop == d0) @(negedge clk_i);
    got = (n_req != r0);
  endtask

  // Hand over the answer, collect n reply bytes, let the driver turn off
  task automatic reply(input fsf_rsp_t r, input int n);
    repeat (10) if (rsp_ready !== 1'b1) @(negedge clk_i);
    chk(rsp_ready, 1'b1);
    rsp = r;
    rsp_valid = 1'b1;
    @(negedge clk_i);
    rsp_valid = 1'b0;
    repeat (n * 11 * baud_div + 40) if (m.rx_q.size() < n) @(negedge clk_i);
    repeat (2 * baud_div) @(negedge clk_i);
  endtask

  task automatic cmp_reply(input fsf_bq_t e);
    e.push_back(xsum(e));
    chk(m.rx_q.size(), e.size());
    foreach (e[i]) chk(m.rx_q[i], e[i]);
  endtask

  task automatic t_reset();
    chk({txd, tx_en, rsp_ready, req_valid, frame_drop, overrun}, 6'b100000);
  endtask

  // Process data over both address formats and two bit rates
  task automatic t_proc();
    logic [7:0] adr[4] = '{8'h81, 8'h01, 8'h41, 8'h81};
    fsf_rsp_t r;
    bit got;
    for (int i = 0; i < 4; i++)
    begin
      baud_div = (i == 3) ? 16'h0007 : 16'h0004;
      exchange('{8'h02, 8'h06, adr[i], 8'h12, 8'(i), 8'hab, 8'hcd}, 8'h00, -1, got);
      chk(got, 1'b1);
      chk({last_req.ctrl_word, last_req.reference}, {8'h12, 8'(i), 16'habcd});
      chk({last_req.bcast, last_req.has_param}, 2'b00);
      r = '0;
      r.status_word = {8'h5a, 8'(i)};
      r.out_freq = 16'h0fed;
      reply(r, 8);
      cmp_reply('{8'h02, 8'h06, adr[i], 8'h5a, 8'(i), 8'h0f, 8'hed});
    end
    baud_div = 16'h0004;
    chk(m.rx_bad, 0);
  endtask

  // Parameter frame with a given command and answer
  task automatic param_xchg(input logic [3:0] c, input fsf_res_t code, input logic [7:0] flt);
    fsf_rsp_t r;
    logic [31:0] v;
    bit got;
    exchange('{8'h02, 8'h0e, 8'h81, {c, 4'h1}, 8'h9e, 8'h00, 8'h07, 8'h11, 8'h22, 8'h33, 8'h44,
      8'h0c, 8'h0d, 8'h0e, 8'h0f}, 8'h00, -1, got);
    chk(got, 1'b1);
    chk({last_req.has_param, last_req.cmd, last_req.param_number}, {1'b1, c, 12'h19e});
    chk({last_req.index, last_req.ctrl_word}, 32'h00070c0d);
    chk(last_req.value, 32'h11223344);
    if (c == 4'hf)
      chk({last_req.dec.text, last_req.dec.bad}, 2'b10);
    else
      chk(last_req.dec, xdec(c));
    r = '0;
    r.code = code;
    r.fault = flt;
    r.value = {28'hcafe000, c};
    r.status_word = 16'h4321;
    r.out_freq = 16'h8765;
    v = (code == RES_FAIL) ? {24'h0, flt} : r.value;
    reply(r, 16);
    chk(m.rx_q.size(), 16);
    chk({m.rx_q[0], m.rx_q[1], m.rx_q[2], m.rx_q[3][7:4]}, {8'h02, 8'h0e, 8'h81, code});
    chk({m.rx_q[7], m.rx_q[8], m.rx_q[9], m.rx_q[10]}, v);
    chk({m.rx_q[11], m.rx_q[12], m.rx_q[13], m.rx_q[14]}, 32'h43218765);
    chk(xsum(m.rx_q), 8'h00);
  endtask

  task automatic t_param();
    logic [3:0] cmd[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf, 4'h9};
    fsf_res_t res[8] = '{RES_NONE, RES_WORD, RES_WORD, RES_DWORD, RES_DWORD, RES_WORD, RES_TEXT, RES_FAIL};
    for (int i = 0; i < 8; i++) param_xchg(cmd[i], res[i], FLT_RANGE);
  endtask

  task automatic t_fault();
    logic [7:0] f[9] = '{FLT_NO_PARAM, FLT_NO_WRITE, FLT_RANGE, FLT_NO_SUB, FLT_NO_ARRAY, FLT_TYPE,
      FLT_MODE, FLT_NO_BUS, FLT_FACTORY};
    for (int i = 0; i < 9; i++) param_xchg(4'h1, RES_FAIL, f[i]);
  endtask

  // Stall the answer so queued bytes overflow the FIFO, then drain
  task automatic t_fifo();
    fsf_rsp_t r;
    int o0;
    bit got;
    exchange('{8'h02, 8'h06, 8'h81, 8'h00, 8'h01, 8'h00, 8'h02}, 8'h00, -1, got);
    o0 = n_ovr;
    repeat (34) m.send_byte(8'h55, 1'b0);
    chk(n_ovr != o0, 1'b1);
    r = '0;
    r.status_word = 16'h00aa;
    reply(r, 8);
    cmp_reply('{8'h02, 8'h06, 8'h81, 8'h00, 8'haa, 8'h00, 8'h00});
  endtask

  // Foreign node, broken checksum, broken parity
  task automatic t_drop();
    logic [7:0] adr[4] = '{8'h02, 8'h85, 8'h81, 8'h81};
    int d0;
    bit got;
    for (int i = 0; i < 4; i++)
    begin
      d0 = n_drop;
      exchange('{8'h02, 8'h06, adr[i], 8'h00, 8'h00, 8'h00, 8'h00}, (i == 2) ? 8'h40 : 8'h00, (i == 3) ? 4 : -1, got);
      chk({got, 8'(n_drop - d0)}, 9'h001);
      repeat (20) @(negedge clk_i);
      chk({tx_en, rsp_ready}, 2'b00);
    end
  endtask

  // Six text characters: length is ten plus six, bytes past twelve come back as zero
  task automatic t_text();
    fsf_rsp_t r;
    bit got;
    exchange('{8'h02, 8'h10, 8'h81, 8'hf0, 8'h01, 8'h04, 8'h00, 8'h41, 8'h42, 8'h43, 8'h44, 8'h0c, 8'h0d, 8'h0e,
      8'h0f, 8'h45, 8'h46}, 8'h00, -1, got);
    chk({got, last_req.dec.text, last_req.ctrl_word}, {2'b11, 16'h0c0d});
    r = '0;
    r.code = RES_TEXT;
    reply(r, 18);
    chk(m.rx_q.size(), 18);
    chk({m.rx_q[1], m.rx_q[3][7:4], m.rx_q[15], m.rx_q[16]}, {8'h10, RES_TEXT, 16'h0000});
    chk(xsum(m.rx_q), 8'h00);
  endtask

  // Broadcast in both formats is passed on but never answered
  task automatic t_bcast();
    logic [7:0] adr[2] = '{8'h3e, 8'h80};
    bit got;
    for (int i = 0; i < 2; i++)
    begin
      exchange('{8'h02, 8'h06, adr[i], 8'h00, 8'h00, 8'h00, 8'h00}, 8'h00, -1, got);
      chk({got, last_req.bcast}, 2'b11);
      repeat (100) @(negedge clk_i);
      chk({tx_en, rsp_ready, 8'(m.rx_q.size())}, 10'h000);
    end
  endtask

  initial
  begin
    reset_i = 1'b1;
    rsp_valid = 1'b0;
    rsp = '0;
    node_addr = 7'h01;
    baud_div = 16'h0004;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
    t_reset();
    t_proc();
    t_param();
    t_fault();
    t_text();
    t_fifo();
    t_drop();
    t_bcast();
    summarize();
  end
endmodule
`default_nettype wire
